//--- logic/serial_ctrl_params.svh
`ifndef SERIAL_CTRL_PARAMS_SVH
`define SERIAL_CTRL_PARAMS_SVH
// Global bases and register offsets
`define SC_BASE_BLOCK 16'h0200
`define SC_BASE_NONBLK 16'h0300
`define SC_OFS_CTRL2 16'h0043
`define SC_OFS_STATUS 16'h0044
`define SC_OFS_DATA 16'h0047
// Control bit positions
`define SC_C2_TXE_IE 7
`define SC_C2_TXD_IE 6
`define SC_C2_RXF_IE 5
`define SC_C2_QL_IE 4
`define SC_C2_TX_ON 3
`define SC_C2_RX_ON 2
`define SC_C2_STANDBY 1
`define SC_C2_BREAK 0
// Reset values
`define SC_CTRL2_RST 8'h00
`define SC_STATUS_RST 8'hc0
// Frame lengths in bit times
`define SC_DATA_BITS 4'ha
`define SC_IDLE_BITS 4'ha
`define SC_BRK_BITS 4'ha
`define SC_LBRK_BITS 4'hd
// Bit time in core clocks
`define SC_BIT_CYCLES 16
`endif

//--- logic/serial_ctrl_pkg.sv
package serial_ctrl_pkg;
   typedef struct packed {
      logic tx_buf_empty;
      logic tx_done;
      logic rx_buf_full;
      logic quiet_line;
      logic overrun;
      logic noise_flag;
      logic framing_err;
      logic parity_err;
   } status_s;
   typedef struct packed {
      logic noise_flag;
      logic framing_err;
      logic parity_err;
   } rx_err_s;
   typedef struct packed {
      rx_err_s err;
      logic [7:0] data;
   } rx_word_s;
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_SEND = 2'b01
   } tx_state_e;
   typedef enum logic [1:0] {
      FR_DATA = 2'b00,
      FR_IDLE = 2'b01,
      FR_BREAK = 2'b10
   } frame_kind_e;
endpackage : serial_ctrl_pkg

//--- logic/serial_ctrl_status_regs.sv
`timescale 1ns/1ps
`include "serial_ctrl_params.svh"
module serial_ctrl_status_regs #(
   parameter int BIT_CYCLES = `SC_BIT_CYCLES
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // Register port
   input wire logic [15:0] addr_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   // Configuration levels from the other control registers
   input wire logic loopback_sel_i,
   input wire logic rx_source_sel_i,
   input wire logic one_wire_dir_i,
   input wire logic long_break_sel_i,
   input wire logic wake_sel_i,
   // Receiver core side
   input wire logic rx_valid_i,
   input wire serial_ctrl_pkg::rx_word_s rx_word_i,
   output logic rx_ready_o,
   input wire logic rx_overrun_i,
   input wire logic line_idle_i,
   // Transmit pin
   input wire logic tx_pin_i,
   output logic tx_pin_o,
   output logic tx_pin_oe_o,
   output logic tx_owned_o,
   // Receive pin and receiver input
   input wire logic rx_pin_i,
   output logic rx_owned_o,
   output logic rx_line_o,
   // Interrupt request
   output logic irq_o
);
   generate
      if (BIT_CYCLES < 1 || BIT_CYCLES > 65535) begin : g_bad_cycles
         $error("BIT_CYCLES out of range");
      end
   endgenerate

   // Address decode
   function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
      hit = (a == (`SC_BASE_BLOCK + ofs)) || (a == (`SC_BASE_NONBLK + ofs));
   endfunction : hit

   wire hit_ctrl = hit(addr_i, `SC_OFS_CTRL2);
   wire hit_stat = hit(addr_i, `SC_OFS_STATUS);
   wire hit_data = hit(addr_i, `SC_OFS_DATA);
   wire wr_ctrl = wr_i & hit_ctrl;
   wire wr_data = wr_i & hit_data;
   wire rd_stat = rd_i & hit_stat;
   wire rd_data = rd_i & hit_data;

   // Control register
   logic [7:0] ctrl_ff;
   logic [7:0] nxt_ctrl;
   wire tx_on = ctrl_ff[`SC_C2_TX_ON];
   wire rx_on = ctrl_ff[`SC_C2_RX_ON];
   wire standby = ctrl_ff[`SC_C2_STANDBY];
   wire brk_bit = ctrl_ff[`SC_C2_BREAK];

   // Status flags
   serial_ctrl_pkg::status_s stat_ff;
   serial_ctrl_pkg::status_s nxt_stat;
   logic [7:0] seen_ff; // Flags seen set by a status read

   // Transmit side state
   serial_ctrl_pkg::tx_state_e tx_st_ff;
   serial_ctrl_pkg::tx_state_e nxt_tx_st;
   logic [7:0] tx_hold_ff;
   logic [13:0] shreg_ff;
   logic [13:0] nxt_shreg;
   logic [3:0] bits_ff;
   logic [3:0] nxt_bits;
   logic [15:0] div_ff;
   logic idle_pend_ff;
   logic brk_pend_ff;
   logic tx_line_ff;

   // Receive buffer, two entries
   serial_ctrl_pkg::rx_word_s buf_ff [2];
   logic wptr_ff;
   logic rptr_ff;
   logic [1:0] cnt_ff;
   logic [7:0] rx_data_ff;
   logic idle_arm_ff;

   // Bit-time enable
   wire bit_tick = (div_ff == 16'h0000);
   wire [15:0] nxt_div = bit_tick ? 16'(BIT_CYCLES - 1) : div_ff - 16'h0001;

   // Transmit frame selection; breaks first, then idle, then data
   wire busy = (tx_st_ff == serial_ctrl_pkg::TX_SEND);
   wire want_brk = brk_pend_ff | brk_bit;
   wire data_pend = ~stat_ff.tx_buf_empty;
   wire any_pend = want_brk | idle_pend_ff | data_pend;
   // Pending work drains even with tx_on clear
   wire may_start = tx_on | brk_pend_ff | idle_pend_ff | data_pend;
   wire start = ~busy & bit_tick & may_start & any_pend;
   wire last_bit = busy & bit_tick & (bits_ff == 4'h1);
   wire [3:0] brk_len = long_break_sel_i ? `SC_LBRK_BITS : `SC_BRK_BITS;
   serial_ctrl_pkg::frame_kind_e kind;
   assign kind = want_brk ? serial_ctrl_pkg::FR_BREAK :
                 idle_pend_ff ? serial_ctrl_pkg::FR_IDLE : serial_ctrl_pkg::FR_DATA;
   wire load_data = start & (kind == serial_ctrl_pkg::FR_DATA);

   always_comb begin
      nxt_tx_st = tx_st_ff;
      nxt_shreg = shreg_ff;
      nxt_bits = bits_ff;
      if (start) begin
         nxt_tx_st = serial_ctrl_pkg::TX_SEND;
         case (kind)
            serial_ctrl_pkg::FR_BREAK: begin
               nxt_shreg = 14'h0000;
               nxt_bits = brk_len;
            end
            serial_ctrl_pkg::FR_IDLE: begin
               nxt_shreg = 14'h3fff;
               nxt_bits = `SC_IDLE_BITS;
            end
            default: begin
               nxt_shreg = {5'h1f, tx_hold_ff, 1'b0};
               nxt_bits = `SC_DATA_BITS;
            end
         endcase
      end else if (busy && bit_tick) begin
         nxt_shreg = {1'b1, shreg_ff[13:1]};
         nxt_bits = bits_ff - 4'h1;
         if (bits_ff == 4'h1) begin
            nxt_tx_st = serial_ctrl_pkg::TX_IDLE;
         end
      end
   end

   // Line level: next bit while sending, mark otherwise
   wire nxt_line = start ? nxt_shreg[0] : (busy & ~last_bit) ? nxt_shreg[0] : 1'b1;

   // Pin ownership and direction
   wire own_nxt = tx_on | busy | any_pend;
   wire one_wire = loopback_sel_i & rx_source_sel_i;
   wire oe_nxt = own_nxt & (~one_wire | one_wire_dir_i);
   wire rx_own_nxt = rx_on & ~loopback_sel_i;
   // Loop mode feeds the transmitter back; single wire listens on the pin
   wire rx_line_nxt = ~loopback_sel_i ? rx_pin_i :
                      rx_source_sel_i ? tx_pin_i : tx_line_ff;

   // Control writes and hardware wake-up
   wire tx_rise = wr_ctrl & wdata_i[`SC_C2_TX_ON] & ~tx_on;
   wire brk_set = wr_ctrl & wdata_i[`SC_C2_BREAK];
   wire push = rx_valid_i & rx_ready_o;
   wire wake_mark = push & wake_sel_i & rx_word_i.data[7];
   wire wake_idle = line_idle_i & ~wake_sel_i;
   wire wake = standby & (wake_mark | wake_idle);
   // A standby receiver drops characters until it wakes; a marked wake-up character is kept
   wire keep = ~standby | wake_mark;
   wire do_push = push & keep;

   always_comb begin
      nxt_ctrl = ctrl_ff;
      if (wr_ctrl) begin
         nxt_ctrl = wdata_i;
      end
      if (wake) begin
         nxt_ctrl[`SC_C2_STANDBY] = 1'b0;
      end
   end

   // Receive buffer movement
   wire buf_empty = (cnt_ff == 2'h0);
   wire pop = ~buf_empty & ~stat_ff.rx_buf_full;
   wire [1:0] nxt_cnt = cnt_ff + {1'b0, do_push} - {1'b0, pop};
   serial_ctrl_pkg::rx_word_s head;
   assign head = buf_ff[rptr_ff];

   // Flag clear conditions: status read arms, data access completes; tx_done also clears on a tx_on rise or break write
   wire clr_txe = wr_data & seen_ff[7];
   wire clr_tc = seen_ff[6] & (wr_data | tx_rise | brk_set);
   wire clr_rx = rd_data;
   wire tc_now = stat_ff.tx_buf_empty & ~busy & ~any_pend & ~start;
   wire idle_set = line_idle_i & idle_arm_ff & ~standby;

   // Status next state; a set wins over a same-cycle clear, except tx_done, where a same-cycle clear wins
   always_comb begin
      nxt_stat = stat_ff;
      if (clr_txe) begin
         nxt_stat.tx_buf_empty = 1'b0;
      end
      if (load_data) begin
         nxt_stat.tx_buf_empty = 1'b1;
      end
      if (clr_tc || !tc_now) begin
         nxt_stat.tx_done = 1'b0;
      end
      if (tc_now && !clr_tc) begin
         nxt_stat.tx_done = 1'b1;
      end
      if (clr_rx) begin
         if (seen_ff[5]) begin
            nxt_stat.rx_buf_full = 1'b0;
         end
         if (seen_ff[4]) begin
            nxt_stat.quiet_line = 1'b0;
         end
         if (seen_ff[3]) begin
            nxt_stat.overrun = 1'b0;
         end
         if (seen_ff[2]) begin
            nxt_stat.noise_flag = 1'b0;
         end
         if (seen_ff[1]) begin
            nxt_stat.framing_err = 1'b0;
         end
         if (seen_ff[0]) begin
            nxt_stat.parity_err = 1'b0;
         end
      end
      if (pop) begin
         nxt_stat.rx_buf_full = 1'b1;
         nxt_stat.noise_flag = head.err.noise_flag;
         nxt_stat.framing_err = head.err.framing_err;
         nxt_stat.parity_err = head.err.parity_err;
      end
      if (idle_set) begin
         nxt_stat.quiet_line = 1'b1;
      end
      if (rx_overrun_i) begin
         nxt_stat.overrun = 1'b1;
      end
   end

   // Writes to the status offset fall through untouched
   wire [7:0] rd_mux = hit_ctrl ? ctrl_ff :
                       hit_stat ? stat_ff :
                       hit_data ? rx_data_ff : 8'h00;

   wire irq_nxt = (nxt_ctrl[`SC_C2_TXE_IE] & nxt_stat.tx_buf_empty) |
                  (nxt_ctrl[`SC_C2_TXD_IE] & nxt_stat.tx_done) |
                  (nxt_ctrl[`SC_C2_RXF_IE] & nxt_stat.rx_buf_full) |
                  (nxt_ctrl[`SC_C2_QL_IE] & nxt_stat.quiet_line);

   // Pending idle and break; a new request wins over consumption
   wire nxt_idle_pend = tx_rise | (idle_pend_ff & ~(start & kind == serial_ctrl_pkg::FR_IDLE));
   wire nxt_brk_pend = brk_set | (brk_pend_ff & ~(start & want_brk));

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl_ff <= `SC_CTRL2_RST;
         stat_ff <= `SC_STATUS_RST;
         seen_ff <= 8'h00;
         irq_o <= 1'b0;
         rdata_o <= 8'h00;
      end else begin
         ctrl_ff <= nxt_ctrl;
         stat_ff <= nxt_stat;
         seen_ff <= rd_stat ? stat_ff : (seen_ff & stat_ff);
         irq_o <= irq_nxt;
         rdata_o <= rd_i ? rd_mux : rdata_o;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tx_st_ff <= serial_ctrl_pkg::TX_IDLE;
         shreg_ff <= 14'h3fff;
         bits_ff <= 4'h0;
         div_ff <= 16'h0000;
         tx_hold_ff <= 8'h00;
      end else begin
         tx_st_ff <= nxt_tx_st;
         shreg_ff <= nxt_shreg;
         bits_ff <= nxt_bits;
         div_ff <= nxt_div;
         tx_hold_ff <= wr_data ? wdata_i : tx_hold_ff;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         idle_pend_ff <= 1'b0;
         brk_pend_ff <= 1'b0;
         tx_line_ff <= 1'b1;
         tx_pin_o <= 1'b1;
         tx_pin_oe_o <= 1'b0;
         tx_owned_o <= 1'b0;
         rx_owned_o <= 1'b0;
         rx_line_o <= 1'b1;
      end else begin
         idle_pend_ff <= nxt_idle_pend;
         brk_pend_ff <= nxt_brk_pend;
         tx_line_ff <= nxt_line;
         tx_pin_o <= nxt_line;
         tx_pin_oe_o <= oe_nxt;
         tx_owned_o <= own_nxt;
         rx_owned_o <= rx_own_nxt;
         rx_line_o <= rx_line_nxt;
      end
   end

   // Receive buffer; ready is registered so it tracks the next count
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wptr_ff <= 1'b0;
         rptr_ff <= 1'b0;
         cnt_ff <= 2'h0;
         rx_ready_o <= 1'b0;
         rx_data_ff <= 8'h00;
         idle_arm_ff <= 1'b0;
      end else begin
         wptr_ff <= wptr_ff ^ do_push;
         rptr_ff <= rptr_ff ^ pop;
         cnt_ff <= nxt_cnt;
         rx_ready_o <= (nxt_cnt != 2'h2) & rx_on;
         rx_data_ff <= pop ? head.data : rx_data_ff;
         // Quiet line reports once per burst of received characters
         idle_arm_ff <= pop | (idle_arm_ff & ~idle_set);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (do_push) begin
         buf_ff[wptr_ff] <= rx_word_i;
      end
   end
endmodule : serial_ctrl_status_regs

//--- sim/serial_ctrl_status_regs_chk.sv
`timescale 1ns/1ps
module serial_ctrl_status_regs_chk #(
   parameter int BIT_CYCLES = 16
) (
   // Clock, reset and register port
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic [15:0] addr_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] wdata_i,
   input wire logic [7:0] rdata_o,
   // Pins, configuration and interrupt
   input wire logic loopback_sel_i,
   input wire logic rx_source_sel_i,
   input wire logic one_wire_dir_i,
   input wire logic tx_pin_oe_o,
   input wire logic tx_owned_o,
   input wire logic rx_owned_o,
   input wire logic irq_o
);
   logic [7:0] ctrl_ff;
   logic ctl_hit;
   logic map_hit;
   logic one_wire;
   assign ctl_hit = (addr_i == 16'h0243) || (addr_i == 16'h0343);
   assign map_hit = (addr_i[15:8] == 8'h02) || (addr_i[15:8] == 8'h03);
   assign one_wire = loopback_sel_i && rx_source_sel_i;
   // Software copy; standby bit is cleared by hardware, so never compared
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl_ff <= 8'h00;
      end else if (wr_i && ctl_hit) begin
         ctrl_ff <= wdata_i;
      end
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   a_irq_masked: assert property (ctrl_ff[7:4] == 4'h0 |-> !irq_o)
      else $error("irq with all enables clear");
   // Writes may queue work or clear the flag, so only quiet stretches count
   a_done_irq: assert property ((ctrl_ff[6] && !tx_owned_o && !wr_i) [*3] |=> irq_o)
      else $error("idle transmitter raised no irq");
   a_tx_owned: assert property (ctrl_ff[3] |=> tx_owned_o)
      else $error("transmit pin not owned");
   a_oe_owned: assert property (!tx_owned_o |-> !tx_pin_oe_o)
      else $error("pin driven without ownership");
   a_wire_in: assert property ((one_wire && !one_wire_dir_i) [*2] |-> !tx_pin_oe_o)
      else $error("single wire driven while incoming");
   a_wire_out: assert property (
      (one_wire && one_wire_dir_i && tx_owned_o) [*2] |-> tx_pin_oe_o)
      else $error("single wire not driven while outgoing");
   a_rx_owned: assert property (rx_owned_o == $past(ctrl_ff[2] && !loopback_sel_i))
      else $error("receive pin ownership wrong");
   a_ctrl_read: assert property (rd_i && ctl_hit |=> rdata_o[7:2] == $past(ctrl_ff[7:2]))
      else $error("control readback wrong");
   a_unmapped: assert property (rd_i && !map_hit |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
endmodule : serial_ctrl_status_regs_chk

bind serial_ctrl_status_regs serial_ctrl_status_regs_chk #(.BIT_CYCLES(BIT_CYCLES)) u_chk (
   .core_clk_i(core_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
   .wdata_i(wdata_i), .rdata_o(rdata_o), .loopback_sel_i(loopback_sel_i),
   .rx_source_sel_i(rx_source_sel_i), .one_wire_dir_i(one_wire_dir_i),
   .tx_pin_oe_o(tx_pin_oe_o), .tx_owned_o(tx_owned_o), .rx_owned_o(rx_owned_o),
   .irq_o(irq_o));

//--- sim/serial_node_model.sv
`timescale 1ns/1ps
module serial_node_model (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // Bench command
   input wire logic send_i,
   input wire logic [7:0] data_i,
   // Receive stream toward the block
   input wire logic rx_ready_i,
   output logic rx_valid_o,
   output serial_ctrl_pkg::rx_word_s rx_word_o
);
   // Word held until taken, then inverted so stale data never passes
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rx_valid_o <= 1'b0;
         rx_word_o <= '0;
      end else if (send_i) begin
         rx_valid_o <= 1'b1;
         rx_word_o <= {3'h0, data_i};
      end else if (rx_valid_o && rx_ready_i) begin
         rx_valid_o <= 1'b0;
         rx_word_o <= ~rx_word_o;
      end
   end
endmodule : serial_node_model

//--- sim/tb_serial_ctrl_status_regs.sv
`timescale 1ns/1ps
module tb_serial_ctrl_status_regs;
   localparam int BC = 2;
   localparam logic [8:0] FR = 9'h1a5;
   localparam logic [31:0] ROWS [4] = '{32'h0244_3fc0, 32'h0343_f0f0, 32'h0243_0000,
      32'h0544_ff00};
   logic core_clk_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, send = 1'b0;
   logic loopback_sel_i = 1'b0, rx_source_sel_i = 1'b0, one_wire_dir_i = 1'b0;
   logic long_break_sel_i = 1'b0, wake_sel_i = 1'b0, line_idle_i = 1'b0;
   logic [15:0] addr_i = 16'h0000;
   logic [7:0] wdata_i = 8'h00, sdata = 8'h00, v, rdata_o;
   logic rx_valid_i, rx_ready_o, tx_pin_i, tx_pin_o, tx_pin_oe_o, tx_owned_o;
   logic rx_owned_o, irq_o, rx_line_o, rx_pin = 1'b1, ovr = 1'b0;
   serial_ctrl_pkg::rx_word_s rx_word_i;
   int failures = 0, cmp_count = 0, cycles = 0, zeros = 0, k, n;
   always #5 core_clk_i = ~core_clk_i;
   // Pulled-up wire: a released pin reads as mark
   assign tx_pin_i = tx_pin_oe_o ? tx_pin_o : 1'b1;
   serial_ctrl_status_regs #(.BIT_CYCLES(BC)) dut (
      .core_clk_i(core_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
      .wdata_i(wdata_i), .rdata_o(rdata_o), .loopback_sel_i(loopback_sel_i),
      .rx_source_sel_i(rx_source_sel_i), .one_wire_dir_i(one_wire_dir_i),
      .long_break_sel_i(long_break_sel_i), .wake_sel_i(wake_sel_i), .rx_valid_i(rx_valid_i),
      .rx_word_i(rx_word_i), .rx_ready_o(rx_ready_o), .rx_overrun_i(ovr),
      .line_idle_i(line_idle_i), .tx_pin_i(tx_pin_i), .tx_pin_o(tx_pin_o),
      .tx_pin_oe_o(tx_pin_oe_o), .tx_owned_o(tx_owned_o), .rx_pin_i(rx_pin),
      .rx_owned_o(rx_owned_o), .rx_line_o(rx_line_o), .irq_o(irq_o));
   serial_node_model node (
      .core_clk_i(core_clk_i), .nrst_i(nrst_i), .send_i(send), .data_i(sdata),
      .rx_ready_i(rx_ready_o), .rx_valid_o(rx_valid_i), .rx_word_o(rx_word_i));
   task automatic results();
      $display("comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      cmp_count++;
      if (s !== e) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge core_clk_i);
      addr_i = a;
      wdata_i = d;
      wr_i = 1'b1;
      @(negedge core_clk_i);
      wr_i = 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(negedge core_clk_i);
      addr_i = a;
      rd_i = 1'b1;
      @(negedge core_clk_i);
      rd_i = 1'b0;
      d = rdata_o;
   endtask : rd
   task automatic snd(input logic [7:0] d);
      @(negedge core_clk_i);
      send = 1'b1;
      sdata = d;
      @(negedge core_clk_i);
      send = 1'b0;
      repeat (6) @(negedge core_clk_i);
   endtask : snd
   task automatic low();
      k = 0;
      while (tx_pin_o !== 1'b0 && k < 200) begin
         @(negedge core_clk_i);
         k++;
      end
   endtask : low
   always @(posedge core_clk_i) begin
      cycles++;
      // Low line cycles, so break lengths do not depend on the divider phase
      if (tx_pin_o === 1'b0) begin
         zeros++;
      end
      if (cycles == 5000) begin
         failures++;
         results();
      end
   end
   initial begin
      repeat (4) @(negedge core_clk_i);
      nrst_i = 1'b1;
      chk("tx pin", 8'h01, tx_pin_o);
      foreach (ROWS[i]) begin
         wr(ROWS[i][31:16], ROWS[i][15:8]);
         rd(ROWS[i][31:16] ^ 16'h0100, v);
         chk("readback", ROWS[i][7:0], v);
      end
      chk("rx ready off", 8'h00, rx_ready_o);
      for (int b = 6; b < 8; b++) begin
         wr(16'h0243, 8'h01 << b);
         repeat (3) @(negedge core_clk_i);
         chk("irq on", 8'h01, irq_o);
      end
      wr(16'h0243, 8'h24);
      repeat (2) @(negedge core_clk_i);
      chk("irq off", 8'h00, irq_o);
      chk("rx ready on", 8'h01, rx_ready_o);
      rx_pin = 1'b0;
      repeat (2) @(negedge core_clk_i);
      chk("rx line", 8'h00, rx_line_o);
      rx_pin = 1'b1;
      snd(8'h5a);
      chk("irq rx", 8'h01, irq_o);
      rd(16'h0244, v);
      chk("status", 8'he0, v);
      rd(16'h0247, v);
      chk("data", 8'h5a, v);
      wr(16'h0243, 8'h14);
      line_idle_i = 1'b1;
      @(negedge core_clk_i);
      line_idle_i = 1'b0;
      repeat (3) @(negedge core_clk_i);
      chk("irq quiet", 8'h01, irq_o);
      rd(16'h0244, v);
      rd(16'h0247, v);
      wake_sel_i = 1'b1;
      wr(16'h0243, 8'h06);
      snd(8'h12);
      rd(16'h0243, v);
      chk("standby", 8'h06, v);
      snd(8'h92);
      rd(16'h0243, v);
      chk("woken", 8'h04, v);
      rd(16'h0244, v);
      chk("wake status", 8'he0, v);
      loopback_sel_i = 1'b1;
      rx_source_sel_i = 1'b1;
      rx_pin = 1'b0;
      wr(16'h0243, 8'h0c);
      repeat (3) @(negedge core_clk_i);
      chk("rx owned", 8'h00, rx_owned_o);
      chk("oe in", 8'h00, tx_pin_oe_o);
      chk("rx line one", 8'h01, rx_line_o);
      one_wire_dir_i = 1'b1;
      repeat (3) @(negedge core_clk_i);
      chk("oe out", 8'h01, tx_pin_oe_o);
      loopback_sel_i = 1'b0;
      rx_source_sel_i = 1'b0;
      rx_pin = 1'b1;
      repeat (30) @(negedge core_clk_i);
      rd(16'h0244, v);
      wr(16'h0247, FR[7:0]);
      wr(16'h0243, 8'h00);
      low();
      chk("owned", 8'h01, tx_owned_o);
      for (int i = 0; i < 9; i++) begin
         repeat (BC) @(negedge core_clk_i);
         chk("tx bit", {7'h00, FR[i]}, tx_pin_o);
      end
      repeat (4 * BC) @(negedge core_clk_i);
      chk("released", 8'h00, tx_owned_o);
      rd(16'h0244, v);
      chk("tx empty", 8'he0, v);
      wr(16'h0243, 8'h08);
      repeat (30) @(negedge core_clk_i);
      for (int lb = 0; lb < 2; lb++) begin
         long_break_sel_i = lb[0];
         n = zeros;
         wr(16'h0243, 8'h09);
         wr(16'h0243, 8'h08);
         repeat (40) @(negedge core_clk_i);
         // Bit cleared before the first break ends, so exactly one is sent
         k = lb ? 13 * BC : 10 * BC;
         chk("break", 8'(k), 8'(zeros - n));
      end
      // Bit held past the second break start but not the third
      long_break_sel_i = 1'b0;
      n = zeros;
      wr(16'h0243, 8'h09);
      repeat (30) @(negedge core_clk_i);
      wr(16'h0243, 8'h08);
      repeat (40) @(negedge core_clk_i);
      chk("held break", 8'(20 * BC), 8'(zeros - n));
      ovr = 1'b1;
      @(negedge core_clk_i);
      ovr = 1'b0;
      rd(16'h0244, v);
      chk("overrun", 8'he8, v);
      nrst_i = 1'b0;
      @(negedge core_clk_i);
      nrst_i = 1'b1;
      rd(16'h0244, v);
      chk("status reset", 8'hc0, v);
      results();
   end
endmodule : tb_serial_ctrl_status_regs
